// ---- design/lltc_pkg.sv ----
// Purpose: Shared constants and types for the light level threshold compare block
// Assumes: Thresholds are 8-bit codes, measurements are 13-bit front end samples
// Notes: All scaling is done by shifts derived from the step sizes below
package lltc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_S1_OFFICE_TRIP = 8'h33;
    localparam logic [7:0] ADDR_S1_OFFICE_HYS = 8'h34;
    localparam logic [7:0] ADDR_S1_DARK_TRIP = 8'h35;
    localparam logic [7:0] ADDR_S1_DARK_HYS = 8'h36;
    localparam logic [7:0] ADDR_S2_OFFICE_TRIP = 8'h37;
    localparam logic [7:0] ADDR_S2_OFFICE_HYS = 8'h38;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int THR_W = 8;
    localparam int THR_LSB = 0;
    localparam logic [7:0] THR_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ************************************************************
    // Scaling: step sizes in nanoamps
    // ************************************************************
    localparam int MEAS_W = 13;
    localparam int CMP_W = 14;
    localparam int FULL_SCALE_UA = 1000;
    localparam int MEAS_STEP_NA = 125;
    localparam int OFFICE_STEP_NA = 4000;
    localparam int DARK_STEP_NA = 500;
    localparam int OFFICE_SHIFT = $clog2(OFFICE_STEP_NA / MEAS_STEP_NA);
    localparam int DARK_SHIFT = $clog2(DARK_STEP_NA / MEAS_STEP_NA);

    // ************************************************************
    // Brightness modes, one-hot
    // ************************************************************
    typedef enum logic [2:0] {
        LLTC_OUTDOOR = 3'h1,
        LLTC_OFFICE = 3'h2,
        LLTC_DARK = 3'h4
    } lltc_mode_t;

    // Bring an 8-bit threshold code onto the measurement step grid
    function automatic logic [CMP_W-1:0] lltc_scale(input logic [THR_W-1:0] code,
                                                    input int shift);
        logic [CMP_W-1:0] wide;
        wide = CMP_W'(code);
        return wide << shift;
    endfunction

endpackage

// ---- design/lltc_cmp_if.sv ----
// Purpose: Carrier between the register side and one channel comparator
// Assumes: One instance per sensor channel
// Notes: Thresholds arrive as raw codes, scaling happens in the comparator
`timescale 1ns/100ps
interface lltc_cmp_if;
    logic [12:0] sample;
    logic sample_valid;
    logic [7:0] office_trip_value;
    logic [7:0] office_hysteresis_value;
    logic [7:0] dark_trip_value;
    logic [7:0] dark_hysteresis_value;
    logic office_en;
    logic dark_en;
    logic office_level_flag;
    logic dark_level_flag;
    lltc_pkg::lltc_mode_t mode;
    logic change;

    // Comparator side
    modport chan (
        input sample, sample_valid, office_trip_value, office_hysteresis_value,
        input dark_trip_value, dark_hysteresis_value, office_en, dark_en,
        output office_level_flag, dark_level_flag, mode, change
    );

    // Register side
    modport ctrl (
        output sample, sample_valid, office_trip_value, office_hysteresis_value,
        output dark_trip_value, dark_hysteresis_value, office_en, dark_en,
        input office_level_flag, dark_level_flag, mode, change
    );
endinterface

// ---- design/lltc_chan.sv ----
// Purpose: One sensor channel, office and dark level hysteresis comparators
// Assumes: Samples come from the front end on this clock, one per valid
// Notes: Flags move on a valid sample or clear when their enable drops; otherwise they hold
`timescale 1ns/100ps
module lltc_chan (
    input wire logic clk_i,    // Block clock
    input wire logic srst_i,   // Synchronous reset, high
    lltc_cmp_if.chan cmp       // Thresholds in, flags out
);

    // ************************************************************
    // Threshold scaling onto the 0.125 uA grid
    // ************************************************************
    logic [13:0] samp;
    logic [13:0] off_trip_s;
    logic [13:0] off_rise_s;
    logic [13:0] dark_trip_s;
    logic [13:0] dark_rise_s;

    // Sums cannot overflow: 2 x 8160 stays below 2^14
    always_comb
    begin
        samp = {1'b0, cmp.sample};
        off_trip_s = lltc_pkg::lltc_scale(cmp.office_trip_value, lltc_pkg::OFFICE_SHIFT);
        off_rise_s = off_trip_s + lltc_pkg::lltc_scale(cmp.office_hysteresis_value,
                                                       lltc_pkg::OFFICE_SHIFT);
        dark_trip_s = lltc_pkg::lltc_scale(cmp.dark_trip_value, lltc_pkg::DARK_SHIFT);
        dark_rise_s = dark_trip_s + lltc_pkg::lltc_scale(cmp.dark_hysteresis_value,
                                                         lltc_pkg::DARK_SHIFT);
    end

    // ************************************************************
    // Flag and mode state
    // ************************************************************
    logic office_reg;
    logic office_next;
    logic dark_reg;
    logic dark_next;
    lltc_pkg::lltc_mode_t mode_reg;
    lltc_pkg::lltc_mode_t mode_next;
    logic change_reg;
    logic change_next;

    // Set below trip, clear above trip plus hysteresis, else hold
    always_comb
    begin
        office_next = office_reg;
        dark_next = dark_reg;
        if (!cmp.office_en)
            office_next = 1'b0;
        else if (cmp.sample_valid && samp < off_trip_s)
            office_next = 1'b1;
        else if (cmp.sample_valid && samp > off_rise_s)
            office_next = 1'b0;
        if (!cmp.dark_en)
            dark_next = 1'b0;
        else if (cmp.sample_valid && samp < dark_trip_s)
            dark_next = 1'b1;
        else if (cmp.sample_valid && samp > dark_rise_s)
            dark_next = 1'b0;
        // Inside the band neither branch fires, so the flag keeps its state
        case (1'b1)
            dark_next: mode_next = lltc_pkg::LLTC_DARK;
            office_next: mode_next = lltc_pkg::LLTC_OFFICE;
            default: mode_next = lltc_pkg::LLTC_OUTDOOR;
        endcase
        change_next = (office_next != office_reg) || (dark_next != dark_reg);
    end

    // Register only
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            office_reg <= 1'b0;
            dark_reg <= 1'b0;
            mode_reg <= lltc_pkg::LLTC_OUTDOOR;
            change_reg <= 1'b0;
        end
        else
        begin
            office_reg <= office_next;
            dark_reg <= dark_next;
            mode_reg <= mode_next;
            change_reg <= change_next;
        end
    end

    assign cmp.office_level_flag = office_reg;
    assign cmp.dark_level_flag = dark_reg;
    assign cmp.mode = mode_reg;
    assign cmp.change = change_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_office_low;
        cmp.office_en && cmp.sample_valid && samp < off_trip_s;
    endsequence
    sequence s_office_high;
        cmp.office_en && cmp.sample_valid && samp > off_rise_s;
    endsequence
    sequence s_dark_low;
        cmp.dark_en && cmp.sample_valid && samp < dark_trip_s;
    endsequence
    sequence s_dark_high;
        cmp.dark_en && cmp.sample_valid && samp > dark_rise_s;
    endsequence

    a_office_set_low: assert property (s_office_low |=> cmp.office_level_flag && cmp.change || $past(office_reg))
        else $error("office flag not set below trip");
    a_office_clr_high: assert property (s_office_high |=> !cmp.office_level_flag)
        else $error("office flag not cleared above band");
    a_dark_set_low: assert property (s_dark_low |=> cmp.dark_level_flag && cmp.mode == lltc_pkg::LLTC_DARK)
        else $error("dark flag or mode wrong below dark trip");
    a_dark_clr_high: assert property (s_dark_high ##1 cmp.office_level_flag |-> cmp.mode == lltc_pkg::LLTC_OFFICE)
        else $error("dark exit did not fall back to office");
    a_band_hold: assert property (cmp.office_en && cmp.sample_valid && samp >= off_trip_s
                                  && samp <= off_rise_s |=> $stable(cmp.office_level_flag))
        else $error("office flag moved inside hysteresis band");
    a_dark_priority: assert property (cmp.dark_level_flag |-> cmp.mode == lltc_pkg::LLTC_DARK)
        else $error("dark did not take precedence");
    a_idle_stable: assert property (!cmp.sample_valid && $stable(cmp.office_en) && $stable(cmp.dark_en)
                                    && cmp.office_en |=> $stable(cmp.office_level_flag) && !cmp.change)
        else $error("flag moved without a sample");
    a_change_pulse: assert property (cmp.change |-> (cmp.office_level_flag != $past(office_reg))
                                     || (cmp.dark_level_flag != $past(dark_reg)))
        else $error("change pulse without a flag edge");

endmodule

// ---- design/lltc_top.sv ----
// Purpose: Light level threshold compare, two sensor channels with register file
// Assumes: The serial register engine presents one-cycle write strobes and an address
// Notes: Sensor 2 dark comparator registers live elsewhere; its dark path is off here
//
// Function
// - Sensor 1 office flag sets and office mode entered when input below trip.
// - Sensor 1 office flag clears, outdoor mode, when input above trip plus hysteresis.
// - Sensor 1 dark flag sets and dark mode entered when input below dark trip.
// - Sensor 1 dark flag clears, back to office, above dark trip plus hysteresis.
// - Sensor 2 office flag sets when its input falls below its own trip.
// - Sensor 2 office flag clears when input rises above its trip plus hysteresis.
// - Office trip and hysteresis codes weigh 4 uA per step, up to about 1000 uA.
// - Dark trip and hysteresis codes weigh 0.5 uA per step, up to 127.5 uA.
// - Dark result outranks the office result when both are active.
// - Measurement is 13 bits at 0.125 uA; thresholds scaled to that grid.
`timescale 1ns/100ps
module lltc_top (
    input wire logic clk_i,                  // 25 MHz block clock
    input wire logic srst_i,                 // Synchronous reset, high
    input wire logic reg_wr_i,               // Register write strobe
    input wire logic [7:0] reg_addr_i,       // Register address
    input wire logic [7:0] reg_wdata_i,      // Write data
    output logic [7:0] reg_rdata_o,          // Read data for last cycle's address
    input wire logic [12:0] s1_meas_i,       // Sensor 1 sample
    input wire logic s1_meas_valid_i,        // Sensor 1 sample strobe
    input wire logic [12:0] s2_meas_i,       // Sensor 2 sample
    input wire logic s2_meas_valid_i,        // Sensor 2 sample strobe
    input wire logic s1_office_en_i,         // Sensor 1 office comparator on
    input wire logic s1_dark_en_i,           // Sensor 1 dark comparator on
    input wire logic s2_office_en_i,         // Sensor 2 office comparator on
    output logic s1_office_level_flag_o,     // Sensor 1 office flag
    output logic s1_dark_level_flag_o,       // Sensor 1 dark flag
    output logic [2:0] s1_mode_o,            // Sensor 1 mode, one-hot
    output logic s1_change_o,                // Sensor 1 flag edge pulse
    output logic s2_office_level_flag_o,     // Sensor 2 office flag
    output logic [2:0] s2_mode_o,            // Sensor 2 mode, one-hot
    output logic s2_change_o                 // Sensor 2 flag edge pulse
);

    // ************************************************************
    // Threshold registers
    // ************************************************************
    logic [7:0] s1_office_trip_reg;
    logic [7:0] s1_office_trip_next;
    logic [7:0] s1_office_hys_reg;
    logic [7:0] s1_office_hys_next;
    logic [7:0] s1_dark_trip_reg;
    logic [7:0] s1_dark_trip_next;
    logic [7:0] s1_dark_hys_reg;
    logic [7:0] s1_dark_hys_next;
    logic [7:0] s2_office_trip_reg;
    logic [7:0] s2_office_trip_next;
    logic [7:0] s2_office_hys_reg;
    logic [7:0] s2_office_hys_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Write decode; other addresses belong to neighbouring blocks and are ignored
    always_comb
    begin
        s1_office_trip_next = s1_office_trip_reg;
        s1_office_hys_next = s1_office_hys_reg;
        s1_dark_trip_next = s1_dark_trip_reg;
        s1_dark_hys_next = s1_dark_hys_reg;
        s2_office_trip_next = s2_office_trip_reg;
        s2_office_hys_next = s2_office_hys_reg;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                lltc_pkg::ADDR_S1_OFFICE_TRIP: s1_office_trip_next = reg_wdata_i;
                lltc_pkg::ADDR_S1_OFFICE_HYS: s1_office_hys_next = reg_wdata_i;
                lltc_pkg::ADDR_S1_DARK_TRIP: s1_dark_trip_next = reg_wdata_i;
                lltc_pkg::ADDR_S1_DARK_HYS: s1_dark_hys_next = reg_wdata_i;
                lltc_pkg::ADDR_S2_OFFICE_TRIP: s2_office_trip_next = reg_wdata_i;
                lltc_pkg::ADDR_S2_OFFICE_HYS: s2_office_hys_next = reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Read mux, registered so the serial engine sees a clean byte
    always_comb
    begin
        case (reg_addr_i)
            lltc_pkg::ADDR_S1_OFFICE_TRIP: rdata_next = s1_office_trip_reg;
            lltc_pkg::ADDR_S1_OFFICE_HYS: rdata_next = s1_office_hys_reg;
            lltc_pkg::ADDR_S1_DARK_TRIP: rdata_next = s1_dark_trip_reg;
            lltc_pkg::ADDR_S1_DARK_HYS: rdata_next = s1_dark_hys_reg;
            lltc_pkg::ADDR_S2_OFFICE_TRIP: rdata_next = s2_office_trip_reg;
            lltc_pkg::ADDR_S2_OFFICE_HYS: rdata_next = s2_office_hys_reg;
            default: rdata_next = lltc_pkg::RDATA_UNMAPPED;
        endcase
    end

    // Register only
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s1_office_trip_reg <= lltc_pkg::THR_RESET;
            s1_office_hys_reg <= lltc_pkg::THR_RESET;
            s1_dark_trip_reg <= lltc_pkg::THR_RESET;
            s1_dark_hys_reg <= lltc_pkg::THR_RESET;
            s2_office_trip_reg <= lltc_pkg::THR_RESET;
            s2_office_hys_reg <= lltc_pkg::THR_RESET;
            rdata_reg <= lltc_pkg::RDATA_UNMAPPED;
        end
        else
        begin
            s1_office_trip_reg <= s1_office_trip_next;
            s1_office_hys_reg <= s1_office_hys_next;
            s1_dark_trip_reg <= s1_dark_trip_next;
            s1_dark_hys_reg <= s1_dark_hys_next;
            s2_office_trip_reg <= s2_office_trip_next;
            s2_office_hys_reg <= s2_office_hys_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ************************************************************
    // Channel comparators
    // ************************************************************
    lltc_cmp_if s1_if ();
    lltc_cmp_if s2_if ();

    // Sensor 1 has both levels
    assign s1_if.sample = s1_meas_i;
    assign s1_if.sample_valid = s1_meas_valid_i;
    assign s1_if.office_trip_value = s1_office_trip_reg;
    assign s1_if.office_hysteresis_value = s1_office_hys_reg;
    assign s1_if.dark_trip_value = s1_dark_trip_reg;
    assign s1_if.dark_hysteresis_value = s1_dark_hys_reg;
    assign s1_if.office_en = s1_office_en_i;
    assign s1_if.dark_en = s1_dark_en_i;

    // Sensor 2 dark path is held off; its dark thresholds are not in this block
    assign s2_if.sample = s2_meas_i;
    assign s2_if.sample_valid = s2_meas_valid_i;
    assign s2_if.office_trip_value = s2_office_trip_reg;
    assign s2_if.office_hysteresis_value = s2_office_hys_reg;
    assign s2_if.dark_trip_value = lltc_pkg::THR_RESET;
    assign s2_if.dark_hysteresis_value = lltc_pkg::THR_RESET;
    assign s2_if.office_en = s2_office_en_i;
    // Tying the dark enable low keeps sensor 2 out of dark mode for good
    assign s2_if.dark_en = 1'b0;

    lltc_chan u_s1 (
        .clk_i (clk_i),
        .srst_i (srst_i),
        .cmp (s1_if.chan)
    );

    lltc_chan u_s2 (
        .clk_i (clk_i),
        .srst_i (srst_i),
        .cmp (s2_if.chan)
    );

    // Status outputs, all from channel flip-flops
    assign s1_office_level_flag_o = s1_if.office_level_flag;
    assign s1_dark_level_flag_o = s1_if.dark_level_flag;
    assign s1_mode_o = s1_if.mode;
    assign s1_change_o = s1_if.change;
    assign s2_office_level_flag_o = s2_if.office_level_flag;
    assign s2_mode_o = s2_if.mode;
    assign s2_change_o = s2_if.change;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_s1_trip_write: assert property (reg_wr_i && reg_addr_i == lltc_pkg::ADDR_S1_OFFICE_TRIP
                                      |=> ##1 reg_rdata_o == $past(reg_wdata_i, 2)
                                      || $past(reg_addr_i) != lltc_pkg::ADDR_S1_OFFICE_TRIP)
        else $error("sensor 1 office trip readback wrong");
    a_s2_office_set: assert property (s2_office_en_i && s2_meas_valid_i
                                      && 14'(s2_meas_i) < 14'(s2_office_trip_reg) * 14'h0020
                                      |=> s2_office_level_flag_o
                                      && s2_mode_o == lltc_pkg::LLTC_OFFICE)
        else $error("sensor 2 office level not entered");
    a_s2_office_clr: assert property (s2_office_en_i && s2_meas_valid_i
                                      && 14'(s2_meas_i) > (14'(s2_office_trip_reg)
                                      + 14'(s2_office_hys_reg)) * 14'h0020
                                      |=> !s2_office_level_flag_o
                                      && s2_mode_o == lltc_pkg::LLTC_OUTDOOR)
        else $error("sensor 2 outdoor not restored");
    a_s1_dark_scale: assert property (s1_dark_en_i && s1_meas_valid_i
                                      && 14'(s1_meas_i) < 14'(s1_dark_trip_reg) * 14'h0004
                                      |=> s1_dark_level_flag_o)
        else $error("sensor 1 dark scale wrong");

    // Addresses below the threshold window read back as zero
    a_rdata_unmapped: assert property (reg_addr_i < lltc_pkg::ADDR_S1_OFFICE_TRIP
                                       |=> reg_rdata_o == lltc_pkg::RDATA_UNMAPPED)
        else $error("unmapped readback not zero");
    // Office entry on sensor 1, 32 grid steps per code
    a_s1_office_set: assert property (s1_office_en_i && s1_meas_valid_i
                                      && 14'(s1_meas_i) < 14'(s1_office_trip_reg) * 14'h0020
                                      |=> s1_office_level_flag_o)
        else $error("sensor 1 office level not entered");
    // Dark exit on sensor 1, 4 grid steps per code
    a_s1_dark_clr: assert property (s1_dark_en_i && s1_meas_valid_i
                                    && 14'(s1_meas_i) > (14'(s1_dark_trip_reg)
                                    + 14'(s1_dark_hys_reg)) * 14'h0004
                                    |=> !s1_dark_level_flag_o)
        else $error("sensor 1 dark flag not cleared");
    // Each channel shows exactly one mode at a time
    a_mode_onehot: assert property ($onehot(s1_mode_o) && $onehot(s2_mode_o))
        else $error("mode not one-hot");
    // Sensor 2 has no dark path here, so dark mode never shows
    a_s2_no_dark: assert property (s2_mode_o != lltc_pkg::LLTC_DARK)
        else $error("sensor 2 shows dark mode");

endmodule

// ---- bench/lltc_fe_model.sv ----
// Purpose: Behavioural light sensor current front end for one channel
// Assumes: Requests are launched on the falling edge of the block clock
// Notes: Outside a strobe the data bus shows the inverse of the last sample
`timescale 1ns/100ps
module lltc_fe_model (
    input wire logic clk_i,       // Block clock
    output logic [12:0] meas_o,   // Measured current, 0.125 uA steps
    output logic meas_valid_o     // One-cycle sample strobe
);
    // Idle until the first request
    initial
    begin
        meas_o = 13'h1FFF;
        meas_valid_o = 1'b0;
    end

    // One 13-bit sample held for exactly one rising edge
    task automatic send(input logic [12:0] value);
        @(negedge clk_i);
        meas_o = value;
        meas_valid_o = 1'b1;
        @(negedge clk_i);
        meas_valid_o = 1'b0;
        meas_o = ~value; // Stale data must not pass for a fresh sample
    endtask
endmodule

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench for the light level threshold compare block
// Assumes: Readback lags the address by one cycle, flags update on the sample edge
// Notes: Inputs change on the falling edge so no race with the sampling edge
`timescale 1ns/100ps
module tb_top;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [12:0] s1_meas, s2_meas;
    logic s1_valid, s2_valid, s1_office, s1_dark, s1_change, s2_office, s2_change;
    logic s1_office_en = 1'b1;
    logic s1_dark_en = 1'b1;
    logic s2_office_en = 1'b1;
    logic [2:0] s1_mode, s2_mode;
    int fails = 0;
    int compares = 0;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    lltc_fe_model FE1 (.clk_i(clk_i), .meas_o(s1_meas), .meas_valid_o(s1_valid));
    lltc_fe_model FE2 (.clk_i(clk_i), .meas_o(s2_meas), .meas_valid_o(s2_valid));

    lltc_top DUT (
        .clk_i(clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .s1_meas_i(s1_meas), .s1_meas_valid_i(s1_valid),
        .s2_meas_i(s2_meas), .s2_meas_valid_i(s2_valid),
        .s1_office_en_i(s1_office_en), .s1_dark_en_i(s1_dark_en),
        .s2_office_en_i(s2_office_en), .s1_office_level_flag_o(s1_office),
        .s1_dark_level_flag_o(s1_dark), .s1_mode_o(s1_mode), .s1_change_o(s1_change),
        .s2_office_level_flag_o(s2_office), .s2_mode_o(s2_mode), .s2_change_o(s2_change)
    );

    // ************************************************************
    // Compare and bus tasks
    // ************************************************************
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t readback %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp_mode(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t mode %b expected %b", $time, got, exp);
        end
    endtask

    // One write strobe, released a whole cycle later
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = addr;
        reg_wdata_i = data;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    // Address first, data judged after the next rising edge
    task automatic reg_check(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge clk_i);
        reg_addr_i = addr;
        @(negedge clk_i);
        cmp_reg(reg_rdata_o, exp);
    endtask

    task automatic s1_check(input logic off, input logic drk, input logic [2:0] md,
                            input logic chg);
        cmp_bit(s1_office, off);
        cmp_bit(s1_dark, drk);
        cmp_mode(s1_mode, md);
        cmp_bit(s1_change, chg);
    endtask

    task automatic s2_check(input logic off, input logic [2:0] md, input logic chg);
        cmp_bit(s2_office, off);
        cmp_mode(s2_mode, md);
        cmp_bit(s2_change, chg);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset values, readback of every threshold, unmapped places read zero
    task automatic test_regs();
        for (int i = 0; i < 6; i++)
            reg_check(8'h33 + 8'(i), lltc_pkg::THR_RESET);
        for (int i = 0; i < 6; i++)
            reg_write(8'h33 + 8'(i), 8'hA1 + 8'(i));
        reg_write(8'h39, 8'h5A);
        for (int i = 0; i < 6; i++)
            reg_check(8'h33 + 8'(i), 8'hA1 + 8'(i));
        reg_check(8'h39, 8'h00);
        reg_check(8'h32, 8'h00);
    endtask

    // Office trip 16 codes is 512 steps, release above 18 codes, 576 steps
    task automatic test_office1();
        reg_write(8'h33, 8'h10);
        reg_write(8'h34, 8'h02);
        reg_write(8'h35, 8'h00);
        FE1.send(13'd512);
        s1_check(1'b0, 1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b0);
        FE1.send(13'd511);
        s1_check(1'b1, 1'b0, lltc_pkg::LLTC_OFFICE, 1'b1);
        FE1.send(13'd576);
        s1_check(1'b1, 1'b0, lltc_pkg::LLTC_OFFICE, 1'b0);
        FE1.send(13'd577);
        s1_check(1'b0, 1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b1);
    endtask

    // Dark trip 32 codes is 128 steps, release above 36 codes, 144 steps
    task automatic test_dark1();
        reg_write(8'h35, 8'h20);
        reg_write(8'h36, 8'h04);
        FE1.send(13'd127);
        s1_check(1'b1, 1'b1, lltc_pkg::LLTC_DARK, 1'b1);
        FE1.send(13'd144);
        s1_check(1'b1, 1'b1, lltc_pkg::LLTC_DARK, 1'b0);
        FE1.send(13'd145);
        s1_check(1'b1, 1'b0, lltc_pkg::LLTC_OFFICE, 1'b1);
        FE1.send(13'd100);
        s1_check(1'b1, 1'b1, lltc_pkg::LLTC_DARK, 1'b1);
        s1_dark_en = 1'b0;
        @(negedge clk_i);
        s1_check(1'b1, 1'b0, lltc_pkg::LLTC_OFFICE, 1'b1);
        FE1.send(13'd50);
        s1_check(1'b1, 1'b0, lltc_pkg::LLTC_OFFICE, 1'b0);
        s1_dark_en = 1'b1;
    endtask

    // Sensor 2 at the top code: 255 codes is 8160 steps
    task automatic test_office2();
        reg_write(8'h37, 8'hFF);
        reg_write(8'h38, 8'h00);
        FE2.send(13'd8160);
        s2_check(1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b0);
        FE2.send(13'd8159);
        s2_check(1'b1, lltc_pkg::LLTC_OFFICE, 1'b1);
        FE2.send(13'd8160);
        s2_check(1'b1, lltc_pkg::LLTC_OFFICE, 1'b0);
        FE2.send(13'd8161);
        s2_check(1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b1);
        s1_check(1'b1, 1'b0, lltc_pkg::LLTC_OFFICE, 1'b0);
    endtask

    // Dropping an enable clears its flag once; samples are then ignored
    task automatic test_enables();
        FE2.send(13'd8000);
        s2_check(1'b1, lltc_pkg::LLTC_OFFICE, 1'b1);
        s1_office_en = 1'b0;
        s2_office_en = 1'b0;
        @(negedge clk_i);
        s1_check(1'b0, 1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b1);
        s2_check(1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b1);
        FE1.send(13'd200);
        FE2.send(13'd10);
        s2_check(1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b0);
        s1_office_en = 1'b1;
        s2_office_en = 1'b1;
        FE1.send(13'd200);
        s1_check(1'b1, 1'b0, lltc_pkg::LLTC_OFFICE, 1'b1);
    endtask

    // Reset in mid-run returns thresholds and flags to their reset state
    task automatic test_reset();
        srst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        s1_check(1'b0, 1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b0);
        s2_check(1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b0);
        reg_check(8'h33, lltc_pkg::THR_RESET);
    endtask

    // ************************************************************
    // Verdict, watchdog and main sequence
    // ************************************************************
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Tests need about 110 cycles; reaching the 3000-cycle limit means a hang
    initial
    begin
        #(40 * 3000);
        fails++;
        print_verdict();
    end

    initial
    begin
        repeat (12) @(negedge clk_i);
        srst_i = 1'b0;
        s1_check(1'b0, 1'b0, lltc_pkg::LLTC_OUTDOOR, 1'b0);
        test_regs();
        test_office1();
        test_dark1();
        test_office2();
        test_enables();
        test_reset();
        print_verdict();
    end
endmodule
